// [verilog/mpc_pkg.sv]
// Register map, field layout and bus constants of the memory port control bank
package mpc_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CACHE_SELECT = 8'h00;
  localparam logic [7:0] OFS_GEOMETRY_ID  = 8'h04;
  localparam logic [7:0] OFS_INSTR_TCM    = 8'h08;
  localparam logic [7:0] OFS_DATA_TCM     = 8'h0C;
  localparam logic [7:0] OFS_PERIPH_PORT  = 8'h10;
  localparam int         ADDR_LSB         = 2;
  localparam int         ADDR_DEC_W       = 8;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CSEL_TYPE_BIT  = 0;
  localparam int CSEL_LEVEL_LSB = 1;
  localparam int CSEL_LEVEL_W   = 3;
  localparam int TCM_EN_BIT     = 0;
  localparam int TCM_MERGE_BIT  = 1;
  localparam int TCM_RETRY_BIT  = 2;
  localparam int TCM_SIZE_LSB   = 3;
  localparam int TCM_SIZE_W     = 4;
  localparam int PP_EN_BIT      = 0;
  localparam int PP_SIZE_LSB    = 1;
  localparam int PP_SIZE_W      = 3;
  localparam int TCM_CTRL_W     = 3;

  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic                    CTYPE_DATA   = 1'b0;
  localparam logic                    CTYPE_INSTR  = 1'b1;
  localparam logic [CSEL_LEVEL_W-1:0] LEVEL_ONE    = 3'h0;
  localparam logic                    RST_BIT      = 1'b0;
  localparam logic [TCM_SIZE_W-1:0]   RST_TCM_SIZE = 4'h0;
  localparam logic [PP_SIZE_W-1:0]    RST_PP_SIZE  = 3'h0;
  localparam logic [31:0]             RST_WORD     = 32'h0000_0000;
  localparam logic [31:0] DEF_DCACHE_GEOM = 32'hF01F_E019;
  localparam logic [31:0] DEF_ICACHE_GEOM = 32'hF03F_E009;

  // ************************************************************
  // Bus answers and states
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int         PROT_PRIV   = 0;

  typedef enum logic [2:0] {
    REG_CSEL = 3'b000,
    REG_GEOM = 3'b001,
    REG_ITCM = 3'b010,
    REG_DTCM = 3'b011,
    REG_PP   = 3'b100,
    REG_NONE = 3'b111
  } mpc_reg_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } mpc_wr_state_t;

endpackage

// [verilog/mpc_tcm_if.sv]
// Connection between the bank and one tightly coupled memory control register
`timescale 1ns/1ps
interface mpc_tcm_if;
  import mpc_pkg::*;
  logic                  load;
  logic [TCM_SIZE_W-1:0] sizeCfg;
  logic                  retryInit;
  logic                  mergeInit;
  logic                  enInit;
  logic                  wrEn;
  logic [TCM_CTRL_W-1:0] wrData;
  logic [31:0]           readVal;
  logic                  retryEn;
  logic                  mergeEn;
  logic                  tcmEn;

  modport ctrl (
    input  load, sizeCfg, retryInit, mergeInit, enInit, wrEn, wrData,
    output readVal, retryEn, mergeEn, tcmEn
  );
  modport bank (
    output load, sizeCfg, retryInit, mergeInit, enInit, wrEn, wrData,
    input  readVal, retryEn, mergeEn, tcmEn
  );
endinterface

// [verilog/mpc_tcm_ctrl.sv]
// One tightly coupled memory control register, same layout for both sides
`timescale 1ns/1ps
module mpc_tcm_ctrl
  import mpc_pkg::*;
(
  input  wire logic core_clk, // Core clock
  input  wire logic rst_n,    // Asynchronous reset
  input  wire logic core_ce,  // Clock enable
  mpc_tcm_if.ctrl   tcm       // Register connection
);

  logic [TCM_SIZE_W-1:0] sizeField;
  logic [TCM_SIZE_W-1:0] next_sizeField;
  logic                  retry;
  logic                  next_retry;
  logic                  merge;
  logic                  next_merge;
  logic                  enable;
  logic                  next_enable;

  always_comb begin
    next_sizeField = sizeField;
    next_retry     = retry;
    next_merge     = merge;
    next_enable    = enable;
    if (tcm.load) begin
      next_sizeField = tcm.sizeCfg;                    // R06
      next_retry     = tcm.retryInit;                  // R07
      next_merge     = tcm.mergeInit;                  // R08
      next_enable    = tcm.enInit;                     // R09
    end else if (tcm.wrEn) begin
      // Size field is read-only; only the three control bits take writes
      next_retry  = tcm.wrData[TCM_RETRY_BIT];         // R07
      next_merge  = tcm.wrData[TCM_MERGE_BIT];         // R08
      next_enable = tcm.wrData[TCM_EN_BIT];            // R09
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sizeField <= RST_TCM_SIZE;
      retry     <= RST_BIT;
      merge     <= RST_BIT;
      enable    <= RST_BIT;
    end else if (core_ce) begin
      sizeField <= next_sizeField;
      retry     <= next_retry;
      merge     <= next_merge;
      enable    <= next_enable;
    end
  end

  always_comb begin
    tcm.readVal = RST_WORD;
    tcm.readVal[TCM_SIZE_LSB +: TCM_SIZE_W] = sizeField; // R05
    tcm.readVal[TCM_RETRY_BIT] = retry;
    tcm.readVal[TCM_MERGE_BIT] = merge;
    tcm.readVal[TCM_EN_BIT]    = enable;
  end

  assign tcm.retryEn = retry;
  assign tcm.mergeEn = merge;
  assign tcm.tcmEn   = enable;

endmodule

// [verilog/mpc_regs.sv]
// Memory port control register bank with an AXI4-Lite slave port
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

// Function
// R01: Bit 0 of the cache selection register is read/write and picks the cache described by the geometry read.
// R02: A select value of zero means the data cache and one means the instruction cache.
// R03: Bits 3 to 1 of the selection register always read zero (level one) and ignore writes.
// R04: The read-only geometry register returns the data of the cache that the select bit names.
// R05: Each memory control register shows a read-only size code in bits 6 to 3, zero meaning absent.
// R06: The size codes reset from the instruction-side and data-side size configuration inputs.
// R07: Bit 2 enables honouring the retry signal and resets from its own initialisation input.
// R08: Bit 1 makes narrow writes read-modify-write and resets from its own initialisation input.
// R09: With bit 0 clear all accesses of that region go to the main system port; it resets from an input.
// R10: Two memory control registers of identical layout exist, one instruction-side and one data-side.
// R11: The peripheral port register shows a read-only size code in bits 3 to 1 reset from its size inputs.
// R12: Peripheral enable bit 0 routes to the peripheral port when set, else to the main port.
// R13: Software reaches these registers only from privileged execution.
module mpc_regs
  import mpc_pkg::*;
#(
  parameter logic [31:0] DCACHE_GEOM = DEF_DCACHE_GEOM,
  parameter logic [31:0] ICACHE_GEOM = DEF_ICACHE_GEOM
) (
  input  wire logic                  core_clk,        // Core clock
  input  wire logic                  rst_n,           // Async reset
  input  wire logic                  core_ce,         // Clock enable
  // AXI4-Lite slave
  input  wire logic [31:0]           s_axi_awaddr,    // Write address
  input  wire logic [2:0]            s_axi_awprot,    // Write protection
  input  wire logic                  s_axi_awvalid,   // Write addr valid
  output      logic                  s_axi_awready,   // Write addr ready
  input  wire logic [31:0]           s_axi_wdata,     // Write data
  input  wire logic [3:0]            s_axi_wstrb,     // Write strobes
  input  wire logic                  s_axi_wvalid,    // Write data valid
  output      logic                  s_axi_wready,    // Write data ready
  output      logic [1:0]            s_axi_bresp,     // Write response
  output      logic                  s_axi_bvalid,    // Write resp valid
  input  wire logic                  s_axi_bready,    // Write resp ready
  input  wire logic [31:0]           s_axi_araddr,    // Read address
  input  wire logic [2:0]            s_axi_arprot,    // Read protection
  input  wire logic                  s_axi_arvalid,   // Read addr valid
  output      logic                  s_axi_arready,   // Read addr ready
  output      logic [31:0]           s_axi_rdata,     // Read data
  output      logic [1:0]            s_axi_rresp,     // Read response
  output      logic                  s_axi_rvalid,    // Read data valid
  input  wire logic                  s_axi_rready,    // Read data ready
  // Configuration straps
  input  wire logic [TCM_SIZE_W-1:0] instr_tcm_size_cfg,  // I size code
  input  wire logic [TCM_SIZE_W-1:0] data_tcm_size_cfg,   // D size code
  input  wire logic [PP_SIZE_W-1:0]  peripheral_size_cfg, // Periph size
  input  wire logic [1:0]            retry_init_input,    // Retry, [0]=I
  input  wire logic [1:0]            merge_init_input,    // Merge, [0]=I
  input  wire logic [1:0]            tcm_enable_init_input, // En, [0]=I
  input  wire logic                  peripheral_enable_init_input, // PP en
  // Control outputs
  output      logic                  cacheTypeSelect, // 1 = instr cache
  output      logic                  instrRetryHonour, // I retry enable
  output      logic                  instrMergeEn,    // I PARTIAL_WRITE_MERGE_BIT enable
  output      logic                  instrTcmEn,      // I memory enable
  output      logic                  instrToMainPort, // I region to main
  output      logic                  dataRetryHonour, // D retry enable
  output      logic                  dataMergeEn,     // D PARTIAL_WRITE_MERGE_BIT enable
  output      logic                  dataTcmEn,       // D memory enable
  output      logic                  dataToMainPort,  // D region to main
  output      logic                  periphPortEn,    // Periph enable
  output      logic                  periphToMainPort // Periph to main
);

  // ************************************************************
  // Decoding
  // ************************************************************
  function automatic mpc_reg_t decodeReg(input logic [31:0] addr);
    logic [ADDR_DEC_W-1:0] low;
    low = addr[ADDR_DEC_W-1:0];
    decodeReg = REG_NONE;
    if (addr[31:ADDR_DEC_W] == '0) begin
      case (low)
        OFS_CACHE_SELECT: decodeReg = REG_CSEL;
        OFS_GEOMETRY_ID:  decodeReg = REG_GEOM;
        OFS_INSTR_TCM:    decodeReg = REG_ITCM;
        OFS_DATA_TCM:     decodeReg = REG_DTCM;
        OFS_PERIPH_PORT:  decodeReg = REG_PP;
        default:          decodeReg = REG_NONE;
      endcase
    end
  endfunction

  // ************************************************************
  // Strap capture
  // ************************************************************
  // Straps are sampled on the first enabled edge after reset, so the
  // asynchronous reset itself only loads constants.
  logic loaded;
  logic next_loaded;
  logic loadNow;

  assign loadNow = !loaded;

  always_comb begin
    next_loaded = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded <= 1'b0;
    end else if (core_ce) begin
      loaded <= next_loaded;
    end
  end

  // ************************************************************
  // Write channel
  // ************************************************************
  mpc_wr_state_t wrState;
  mpc_wr_state_t next_wrState;
  logic          awHeld;
  logic          next_awHeld;
  logic          wHeld;
  logic          next_wHeld;
  logic [31:0]   awAddr;
  logic [31:0]   next_awAddr;
  logic          awPriv;
  logic          next_awPriv;
  logic [31:0]   wData;
  logic [31:0]   next_wData;
  logic          wLow;
  logic          next_wLow;
  logic [1:0]    bResp;
  logic [1:0]    next_bResp;
  logic          wrCommit;
  mpc_reg_t      wrReg;

  assign s_axi_awready = loaded && (wrState == WR_IDLE) && !awHeld;
  assign s_axi_wready  = loaded && (wrState == WR_IDLE) && !wHeld;
  assign s_axi_bvalid  = (wrState == WR_RESP);
  assign s_axi_bresp   = bResp;
  assign wrCommit      = (wrState == WR_IDLE) && awHeld && wHeld;
  assign wrReg         = decodeReg(awAddr);

  always_comb begin
    next_wrState = wrState;
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_awAddr  = awAddr;
    next_awPriv  = awPriv;
    next_wData   = wData;
    next_wLow    = wLow;
    next_bResp   = bResp;
    case (wrState)
      WR_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          next_awHeld = 1'b1;
          next_awAddr = s_axi_awaddr;
          next_awPriv = s_axi_awprot[PROT_PRIV];
        end
        if (s_axi_wvalid && s_axi_wready) begin
          next_wHeld = 1'b1;
          next_wData = s_axi_wdata;
          next_wLow  = s_axi_wstrb[0];
        end
        if (wrCommit) begin
          next_awHeld  = 1'b0;
          next_wHeld   = 1'b0;
          next_wrState = WR_RESP;
          if (wrReg == REG_NONE) begin
            next_bResp = RESP_DECERR;
          end else if (!awPriv) begin
            next_bResp = RESP_SLVERR;                  // R13
          end else begin
            next_bResp = RESP_OKAY;
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_wrState = WR_IDLE;
        end
      end
      default: begin
        next_wrState = WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrState <= WR_IDLE;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddr  <= RST_WORD;
      awPriv  <= 1'b0;
      wData   <= RST_WORD;
      wLow    <= 1'b0;
      bResp   <= RESP_OKAY;
    end else if (core_ce) begin
      wrState <= next_wrState;
      awHeld  <= next_awHeld;
      wHeld   <= next_wHeld;
      awAddr  <= next_awAddr;
      awPriv  <= next_awPriv;
      wData   <= next_wData;
      wLow    <= next_wLow;
      bResp   <= next_bResp;
    end
  end

  // Only byte lane 0 holds writable bits; other lanes are ignored.
  logic wrAllowed;
  assign wrAllowed = wrCommit && awPriv && wLow;       // R13

  // ************************************************************
  // Registers held in this module
  // ************************************************************
  logic                 cacheSel;
  logic                 next_cacheSel;
  logic [PP_SIZE_W-1:0] ppSize;
  logic [PP_SIZE_W-1:0] next_ppSize;
  logic                 ppEn;
  logic                 next_ppEn;

  always_comb begin
    next_cacheSel = cacheSel;
    next_ppSize   = ppSize;
    next_ppEn     = ppEn;
    if (loadNow) begin
      next_ppSize = peripheral_size_cfg;               // R11
      next_ppEn   = peripheral_enable_init_input;      // R12
    end else if (wrAllowed && wrReg == REG_CSEL) begin
      next_cacheSel = wData[CSEL_TYPE_BIT];            // R01
    end else if (wrAllowed && wrReg == REG_PP) begin
      next_ppEn = wData[PP_EN_BIT];                    // R12
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cacheSel <= CTYPE_DATA;
      ppSize   <= RST_PP_SIZE;
      ppEn     <= RST_BIT;
    end else if (core_ce) begin
      cacheSel <= next_cacheSel;
      ppSize   <= next_ppSize;
      ppEn     <= next_ppEn;
    end
  end

  // ************************************************************
  // Memory control registers, instruction side then data side
  // ************************************************************
  mpc_tcm_if tcmBus[2] ();

  logic [1:0]            tcmWrHit;
  logic [TCM_SIZE_W-1:0] tcmSizeCfg [2];
  logic [31:0]           tcmReadVal [2];
  logic [1:0]            tcmRetry;
  logic [1:0]            tcmMerge;
  logic [1:0]            tcmEnable;

  assign tcmWrHit[0]   = wrAllowed && (wrReg == REG_ITCM);
  assign tcmWrHit[1]   = wrAllowed && (wrReg == REG_DTCM);
  assign tcmSizeCfg[0] = instr_tcm_size_cfg;           // R06
  assign tcmSizeCfg[1] = data_tcm_size_cfg;            // R06

  for (genvar g = 0; g < 2; g++) begin : g_tcm         // R10
    assign tcmBus[g].load      = loadNow;
    assign tcmBus[g].sizeCfg   = tcmSizeCfg[g];
    assign tcmBus[g].retryInit = retry_init_input[g];
    assign tcmBus[g].mergeInit = merge_init_input[g];
    assign tcmBus[g].enInit    = tcm_enable_init_input[g];
    assign tcmBus[g].wrEn      = tcmWrHit[g];
    assign tcmBus[g].wrData    = wData[TCM_CTRL_W-1:0];
    assign tcmReadVal[g]       = tcmBus[g].readVal;
    assign tcmRetry[g]         = tcmBus[g].retryEn;
    assign tcmMerge[g]         = tcmBus[g].mergeEn;
    assign tcmEnable[g]        = tcmBus[g].tcmEn;

    mpc_tcm_ctrl u_tcm (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .core_ce  (core_ce),
      .tcm      (tcmBus[g])
    );
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  logic        rValid;
  logic        next_rValid;
  logic [31:0] rData;
  logic [31:0] next_rData;
  logic [1:0]  rResp;
  logic [1:0]  next_rResp;
  mpc_reg_t    rdReg;
  logic [31:0] rdWord;

  assign rdReg         = decodeReg(s_axi_araddr);
  assign s_axi_arready = loaded && !rValid;
  assign s_axi_rvalid  = rValid;
  assign s_axi_rdata   = rData;
  assign s_axi_rresp   = rResp;

  always_comb begin
    rdWord = RST_WORD;
    case (rdReg)
      REG_CSEL: begin
        rdWord[CSEL_TYPE_BIT] = cacheSel;              // R01
        rdWord[CSEL_LEVEL_LSB +: CSEL_LEVEL_W] = LEVEL_ONE; // R03
      end
      REG_GEOM: begin
        rdWord = (cacheSel == CTYPE_INSTR) ? ICACHE_GEOM  // R02
                                           : DCACHE_GEOM; // R04
      end
      REG_ITCM: rdWord = tcmReadVal[0];
      REG_DTCM: rdWord = tcmReadVal[1];
      REG_PP: begin
        rdWord[PP_SIZE_LSB +: PP_SIZE_W] = ppSize;     // R11
        rdWord[PP_EN_BIT] = ppEn;
      end
      default: rdWord = RST_WORD;
    endcase
  end

  always_comb begin
    next_rValid = rValid;
    next_rData  = rData;
    next_rResp  = rResp;
    if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      next_rValid = 1'b1;
      if (rdReg == REG_NONE) begin
        next_rData = RST_WORD;
        next_rResp = RESP_DECERR;
      end else if (!s_axi_arprot[PROT_PRIV]) begin
        // Unprivileged reads see zero so no state leaks out
        next_rData = RST_WORD;
        next_rResp = RESP_SLVERR;                      // R13
      end else begin
        next_rData = rdWord;
        next_rResp = RESP_OKAY;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rValid <= 1'b0;
      rData  <= RST_WORD;
      rResp  <= RESP_OKAY;
    end else if (core_ce) begin
      rValid <= next_rValid;
      rData  <= next_rData;
      rResp  <= next_rResp;
    end
  end

  // ************************************************************
  // Routing outputs
  // ************************************************************
  assign cacheTypeSelect  = cacheSel;
  assign instrRetryHonour = tcmRetry[0];               // R07
  assign instrMergeEn     = tcmMerge[0];               // R08
  assign instrTcmEn       = tcmEnable[0];
  assign instrToMainPort  = !tcmEnable[0];             // R09
  assign dataRetryHonour  = tcmRetry[1];               // R07
  assign dataMergeEn      = tcmMerge[1];               // R08
  assign dataTcmEn        = tcmEnable[1];
  assign dataToMainPort   = !tcmEnable[1];             // R09
  assign periphPortEn     = ppEn;
  assign periphToMainPort = !ppEn;                     // R12

endmodule

// [sim/mpc_regs_monitor.sv]
// Bus timing and field checker of the memory port control bank
`timescale 1ns/1ps
module mpc_regs_monitor
  import mpc_pkg::*;
#(
  parameter logic [31:0] DCACHE_GEOM = DEF_DCACHE_GEOM,
  parameter logic [31:0] ICACHE_GEOM = DEF_ICACHE_GEOM
) (
  input wire logic        core_clk,         // Clock
  input wire logic        rst_n,            // Reset
  input wire logic        core_ce,          // Clock enable
  input wire logic [31:0] s_axi_araddr,     // Read address
  input wire logic        s_axi_arvalid,    // Read addr valid
  input wire logic        s_axi_arready,    // Read addr ready
  input wire logic [31:0] s_axi_rdata,      // Read data
  input wire logic [1:0]  s_axi_rresp,      // Read response
  input wire logic        s_axi_rvalid,     // Read valid
  input wire logic        s_axi_rready,     // Read ready
  input wire logic        cacheTypeSelect,  // Cache select
  input wire logic        instrRetryHonour, // I retry
  input wire logic        instrMergeEn,     // I merge
  input wire logic        instrTcmEn,       // I enable
  input wire logic        instrToMainPort,  // I to main
  input wire logic        dataRetryHonour,  // D retry
  input wire logic        dataMergeEn,      // D merge
  input wire logic        dataTcmEn,        // D enable
  input wire logic        dataToMainPort,   // D to main
  input wire logic        periphPortEn,     // P enable
  input wire logic        periphToMainPort  // P to main
);
  logic [31:0] rdAddr;

  // ************************************************************
  // Address of the read under way
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdAddr <= 32'h0;
    end else if (core_ce && s_axi_arvalid && s_axi_arready) begin
      rdAddr <= s_axi_araddr;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence arTaken;
    core_ce && s_axi_arvalid && s_axi_arready;
  endsequence
  // Checked as the answer shows
  sequence okRead(logic [7:0] ofs);
    $rose(s_axi_rvalid) && s_axi_rresp == RESP_OKAY &&
      rdAddr == {24'h00_0000, ofs};
  endsequence

  main_route_a: assert property (
    instrToMainPort == !instrTcmEn && dataToMainPort == !dataTcmEn)
    else $error("main port routing wrong");
  periph_route_a: assert property (
    periphToMainPort == !periphPortEn)
    else $error("peripheral routing wrong");
  read_lat_a: assert property (arTaken |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  csel_read_a: assert property (okRead(OFS_CACHE_SELECT) |->
    s_axi_rdata[3:1] == LEVEL_ONE && s_axi_rdata[0] == cacheTypeSelect)
    else $error("cache select readback wrong");
  geom_read_a: assert property (okRead(OFS_GEOMETRY_ID) |->
    s_axi_rdata == (cacheTypeSelect ? ICACHE_GEOM : DCACHE_GEOM))
    else $error("geometry readback wrong");
  itcm_read_a: assert property (okRead(OFS_INSTR_TCM) |->
    s_axi_rdata[2:0] == {instrRetryHonour, instrMergeEn, instrTcmEn})
    else $error("instr control readback wrong");
  dtcm_read_a: assert property (okRead(OFS_DATA_TCM) |->
    s_axi_rdata[2:0] == {dataRetryHonour, dataMergeEn, dataTcmEn})
    else $error("data control readback wrong");
  pp_read_a: assert property (okRead(OFS_PERIPH_PORT) |->
    s_axi_rdata[0] == periphPortEn)
    else $error("peripheral readback wrong");
endmodule

bind mpc_regs mpc_regs_monitor #(
  .DCACHE_GEOM(DCACHE_GEOM),
  .ICACHE_GEOM(ICACHE_GEOM)
) u_mon (.*);

// [sim/memory_port_control_regs_tb.sv]
// Self-checking bench of the memory port control bank
`timescale 1ns/1ps
module memory_port_control_regs_tb;
  import mpc_pkg::*;
  typedef struct {
    logic [7:0] a; logic [31:0] d; logic [31:0] r; logic [7:0] o;
  } mpc_row_t;
  logic core_clk = 1'b0, rst_n = 1'b0, core_ce = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, peripheral_size_cfg = 3'h4;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] instr_tcm_size_cfg = 4'hA, data_tcm_size_cfg = 4'h3;
  logic [1:0] retry_init_input = 2'h1, merge_init_input = 2'h2;
  logic [1:0] tcm_enable_init_input = 2'h3;
  logic peripheral_enable_init_input = 1'b1;
  logic cacheTypeSelect, instrRetryHonour, instrMergeEn, instrTcmEn;
  logic instrToMainPort, dataRetryHonour, dataMergeEn, dataTcmEn;
  logic dataToMainPort, periphPortEn, periphToMainPort;
  logic [7:0] outs;
  int error_cnt = 0, compares = 0;
  logic [31:0] rstExp [5] = '{32'h0, DEF_DCACHE_GEOM, 32'h55, 32'h1B, 32'h9};
  mpc_row_t rows [9] = '{
    '{8'h00, 32'hFFFFFFFF, 32'h1, 8'hD7},
    '{8'h04, 32'h0, DEF_ICACHE_GEOM, 8'hD7},
    '{8'h08, 32'h0, 32'h50, 8'h87},
    '{8'h08, 32'hFFFFFFFF, 32'h57, 8'hF7},
    '{8'h0C, 32'h4, 32'h1C, 8'hF9},
    '{8'h10, 32'h0, 32'h8, 8'hF8},
    '{8'h10, 32'hFFFFFFFF, 32'h9, 8'hF9},
    '{8'h00, 32'h0, 32'h0, 8'h79},
    '{8'h04, 32'hFFFFFFFF, DEF_DCACHE_GEOM, 8'h79}};

  mpc_regs dut (.*);
  assign outs = {cacheTypeSelect, instrRetryHonour, instrMergeEn,
    instrTcmEn, dataRetryHonour, dataMergeEn, dataTcmEn, periphPortEn};
  always #4 core_clk = ~core_clk;

  // ************************************************************
  // Checking and bus tasks
  // ************************************************************
  task automatic check(input string n, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic axi_write(input logic [31:0] a, d, input logic [3:0] s,
                           input logic [2:0] p);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a; s_axi_awprot <= p; s_axi_wdata <= d;
    s_axi_wstrb <= s; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp; s_axi_bready <= 1'b0; break;
      end
    end
    if (n == 40) begin error_cnt++; report_and_stop(); end
  endtask
  task automatic rd_chk(input logic [31:0] a, exp, input logic [2:0] p,
                        input logic [1:0] er);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a; s_axi_arprot <= p; s_axi_arvalid <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
        check("rdata", s_axi_rdata, exp);
        check("rresp", 32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0; break;
      end
      if (s_axi_rvalid === 1'b1) s_axi_rready <= 1;
    end
    if (n == 40) begin error_cnt++; report_and_stop(); end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd_chk(32'(i * 4), rstExp[i], 3'h1, RESP_OKAY);
    check("outs", 32'(outs), 32'h57);
    foreach (rows[i]) begin
      axi_write({24'h0, rows[i].a}, rows[i].d, 4'hF, 3'h1);
      check("bresp", 32'(rs), 32'(RESP_OKAY));
      rd_chk({24'h0, rows[i].a}, rows[i].r, 3'h1, RESP_OKAY);
      check("outs", 32'(outs), 32'(rows[i].o));
    end
    axi_write(32'h8, 32'h0, 4'hF, 3'h0);
    check("bresp", 32'(rs), 32'(RESP_SLVERR));
    rd_chk(32'h8, 32'h57, 3'h1, RESP_OKAY);
    rd_chk(32'h8, 32'h0, 3'h0, RESP_SLVERR);
    axi_write(32'h10, 32'h0, 4'hE, 3'h1);
    rd_chk(32'h10, 32'h9, 3'h1, RESP_OKAY);
    rd_chk(32'h14, 32'h0, 3'h1, RESP_DECERR);
    axi_write(32'h14, 32'h0, 4'hF, 3'h1);
    check("bresp", 32'(rs), 32'(RESP_DECERR));
    rd_chk(32'h100, 32'h0, 3'h1, RESP_DECERR);
    @(posedge core_clk);
    rst_n <= 1'b0; instr_tcm_size_cfg <= 4'hF; tcm_enable_init_input <= 2'h0;
    peripheral_enable_init_input <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(32'h8, 32'h7C, 3'h1, RESP_OKAY);
    check("outs", 32'(outs), 32'h44);
    check("main", 32'({instrToMainPort, dataToMainPort, periphToMainPort}), 32'h7);
    report_and_stop();
  end
endmodule
